// *** asbp_pkg.sv ***
// Package: constants and carrier types for the async SRAM host controller
package asbp_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------
    // Timing (slower grade, 2.3 V range covers all parts), in ns
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_READ_ACC_NS = 70;
    localparam int T_OUT_HIZ_NS = 30;
    localparam int T_SEL_TO_END_NS = 55;
    localparam int T_WR_PULSE_NS = 50;
    localparam int T_DATA_SETUP_NS = 30;

    // Least times round up, none below one cycle
    localparam int RD_ACC_CYC =
        (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIZ_CYC =
        (T_OUT_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_SEL_CYC_RAW =
        (T_SEL_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PW_CYC =
        (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (WR_SEL_CYC_RAW > WR_PW_CYC) ?
        WR_SEL_CYC_RAW : WR_PW_CYC;

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_ACC_CYC);
    localparam logic [CNT_W-1:0] WR_WAIT = CNT_W'(WR_CYC);
    localparam logic [CNT_W-1:0] HIZ_WAIT = CNT_W'(HIZ_CYC);
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asbp_req_t;

    typedef struct packed {
        logic select_active_low;
        logic select_active_high;
        logic out_enable_n;
        logic read_write;
        logic [ADDR_W-1:0] word_address_inputs;
    } asbp_pins_t;

    localparam asbp_pins_t PINS_IDLE = '{
        select_active_low: 1'b1,
        select_active_high: 1'b0,
        out_enable_n: 1'b1,
        read_write: 1'b1,
        word_address_inputs: '0
    };

endpackage

// *** asbp_sync.sv ***
// Two-flop synchroniser for the returning data byte
module asbp_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] dout_d;

    always_comb begin
        meta_d = din;
        dout_d = meta_q;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= meta_d;
            dout <= dout_d;
        end
    end

endmodule // asbp_sync

// *** asbp_host.sv ***
// Host controller that drives an asynchronous byte-wide static memory
//
// Function
// R01: Read/write select held high during reads
// R02: Select at/after write strobe keeps lines released
// R03: Deselect at/before write end keeps lines released
// R04: Output enable inactive through write: no drive
// R05: Never drive against a possibly driving memory
// R06: Read data valid 25/30 ns after enable
// R07: Read data valid 40/55 ns after select
// R08: Memory drives no sooner than 5 ns
// R09: Lines released 20/25 ns after deselect
// R10: Lines released 20/25 ns after enable off
// R11: Lines released 20/25 ns after write strobe
// R12: Memory may drive at once after write
// R13: Select held 35/45 ns before write ends
// R14: Deselect before entering data retention
// R15: Old data held 10 ns after address change
// R16: Selected read drives addressed byte
// R17: Selected write stores byte at end
// R18: Deselected memory releases lines, ignores controls
module asbp_host
    import asbp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // User request
    input wire logic req_valid,
    input wire asbp_req_t req,
    output logic req_ready,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    // Retention entry request and grant
    input wire logic retain_req,
    output logic retain_ok,
    // Memory pins
    output asbp_pins_t pins,
    input wire logic [DATA_W-1:0] byte_data_lines_i,
    output logic [DATA_W-1:0] byte_data_lines_o,
    output logic byte_data_lines_oe
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_RD_SETTLE,
        ST_WRITE,
        ST_RELEASE,
        ST_RETAIN
    } asbp_state_t;

    asbp_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    asbp_pins_t pins_d;
    logic [DATA_W-1:0] dout_d;
    logic oe_d;
    logic ready_d;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_d;
    logic retain_d;
    logic [DATA_W-1:0] din_sync;

    // Pin data is asynchronous; sample it through two flops
    asbp_sync #(.W(DATA_W)) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .din(byte_data_lines_i),
        .dout(din_sync)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pins_d = pins;
        dout_d = byte_data_lines_o;
        oe_d = byte_data_lines_oe;
        ready_d = 1'b0;
        rdata_d = rd_data;
        rvalid_d = 1'b0;
        retain_d = retain_ok;
        unique case (state_q)
            ST_IDLE: begin
                if (retain_req) begin
                    // Already deselected here, so zero gap suffices [R14]
                    state_d = ST_RETAIN;
                    retain_d = 1'b1;
                end else if (req_valid && req_ready) begin
                    pins_d.word_address_inputs = req.addr;
                    pins_d.select_active_low = 1'b0;
                    pins_d.select_active_high = 1'b1;
                    if (req.write) begin
                        // Strobe low with select, OE held off [R02] [R04]
                        pins_d.read_write = 1'b0;
                        pins_d.out_enable_n = 1'b1;
                        dout_d = req.wdata;
                        oe_d = 1'b1; // [R05]
                        cnt_d = WR_WAIT;
                        state_d = ST_WRITE;
                    end else begin
                        pins_d.read_write = 1'b1; // [R01]
                        pins_d.out_enable_n = 1'b0;
                        oe_d = 1'b0; // [R05]
                        // Wait access plus two sync stages [R06] [R07]
                        cnt_d = RD_WAIT + 4'h2;
                        state_d = ST_READ;
                    end
                end else begin
                    ready_d = 1'b1;
                end
            end
            ST_READ: begin
                if (cnt_q > 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    // Capture while still selected [R15] [R16] [R08]
                    rdata_d = din_sync;
                    rvalid_d = 1'b1;
                    pins_d = PINS_IDLE;
                    pins_d.word_address_inputs =
                        pins.word_address_inputs;
                    cnt_d = HIZ_WAIT;
                    state_d = ST_RD_SETTLE;
                end
            end
            ST_RD_SETTLE: begin
                // Memory may still drive after deselect [R09] [R10] [R05]
                if (cnt_q > 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (cnt_q > 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    // Deselect and strobe high together ends the write
                    // with lines released [R03] [R13] [R17] [R12]
                    pins_d.select_active_low = 1'b1;
                    pins_d.select_active_high = 1'b0;
                    pins_d.read_write = 1'b1;
                    state_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Hold data one cycle past write end (zero hold is legal)
                oe_d = 1'b0;
                ready_d = 1'b1;
                state_d = ST_IDLE;
            end
            ST_RETAIN: begin
                // Deselected memory ignores the rest [R18]
                if (!retain_req) begin
                    retain_d = 1'b0;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                pins_d = PINS_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_RST;
            pins <= PINS_IDLE;
            byte_data_lines_o <= '0;
            byte_data_lines_oe <= 1'b0;
            req_ready <= 1'b0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            retain_ok <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pins <= pins_d;
            byte_data_lines_o <= dout_d;
            byte_data_lines_oe <= oe_d;
            req_ready <= ready_d;
            rd_data <= rdata_d;
            rd_valid <= rvalid_d;
            retain_ok <= retain_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    wire sel_on = !pins.select_active_low && pins.select_active_high;

    a_read_rw_high: assert property ( // [R01]
        @(posedge core_clk) disable iff (srst)
        (sel_on && !pins.out_enable_n) |-> pins.read_write)
        else $error("read/write select low during read");

    a_no_contention: assert property ( // [R05]
        @(posedge core_clk) disable iff (srst)
        byte_data_lines_oe |-> pins.out_enable_n)
        else $error("host drives while output enable active");

    a_write_oe_off: assert property ( // [R04]
        @(posedge core_clk) disable iff (srst)
        !pins.read_write |-> pins.out_enable_n && sel_on)
        else $error("output enable active in write");

    // Select covers the whole strobe; both end on the same edge
    sequence s_wr_start;
        $fell(pins.read_write);
    endsequence
    sequence s_wr_hold;
        (sel_on && !pins.read_write) ##1 (!sel_on && pins.read_write);
    endsequence

    a_write_select: assert property ( // [R13]
        @(posedge core_clk) disable iff (srst)
        s_wr_start |-> s_wr_hold)
        else $error("select not held through write");

    a_write_end: assert property ( // [R03]
        @(posedge core_clk) disable iff (srst)
        $rose(pins.read_write) |-> !sel_on)
        else $error("write ended without deselect");

    a_read_wait: assert property ( // [R06]
        @(posedge core_clk) disable iff (srst)
        $fell(pins.out_enable_n) |-> !rd_valid [*3] ##1 rd_valid)
        else $error("read data captured at wrong time");

    a_release_gap: assert property ( // [R10]
        @(posedge core_clk) disable iff (srst)
        $rose(pins.out_enable_n) && !pins.read_write == 1'b0
        |-> !byte_data_lines_oe [*2])
        else $error("host drove too soon after read");

    a_retain_desel: assert property ( // [R14]
        @(posedge core_clk) disable iff (srst)
        retain_ok |-> pins.select_active_low)
        else $error("retention granted while selected");

endmodule // asbp_host

// *** asbp_sram_model.sv ***
// Behavioural byte-wide static memory facing the host controller
module asbp_sram_model
    import asbp_pkg::*;
(
    // Pins from the host
    input wire asbp_pins_t pins,
    input wire logic [DATA_W-1:0] host_o,
    input wire logic host_oe,
    input wire logic retain_ok,
    // Resolved data lines and host breaches seen
    output logic [DATA_W-1:0] line,
    output int viol
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] dout = '0;
    logic drv = 1'b0;
    logic wr_seen = 1'b0;
    logic sel;
    logic rd_on;
    logic wr_on;
    time t_sel = 0;
    initial viol = 0;
    initial line = '0;
    // -------------------------------------------------------------
    // Selection
    // -------------------------------------------------------------
    assign sel = !pins.select_active_low && pins.select_active_high;
    // Write strobe low or output enable idle keeps lines off
    assign rd_on = sel && !pins.out_enable_n
        && pins.read_write;
    assign wr_on = sel && !pins.read_write;
    function automatic logic [DATA_W-1:0] peek(logic [ADDR_W-1:0] a);
        return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5A);
    endfunction
    // -------------------------------------------------------------
    // Read drive
    // -------------------------------------------------------------
    // Late turn-on with junk, so an early sample by the host shows
    always @(posedge rd_on) begin
        #5 drv = rd_on;
        dout = ~peek(pins.word_address_inputs);
        #25 dout = peek(pins.word_address_inputs);
    end
    always @(negedge rd_on) #10 drv = 1'b0;
    // -------------------------------------------------------------
    // Write and host checks
    // -------------------------------------------------------------
    always @(posedge sel) t_sel = $time;
    always @(posedge wr_on) wr_seen = 1'b1;
    always @(negedge wr_on) begin
        if (wr_seen) begin
            if ($time - t_sel < 45) viol++;
            mem[pins.word_address_inputs] = line;
        end
        wr_seen = 1'b0;
    end
    always @(negedge pins.read_write)
        if (sel && !pins.out_enable_n) viol++;
    always @(host_oe, drv) if (host_oe && drv) viol++;
    always @(retain_ok, sel) if (retain_ok && sel) viol++;
    // Released lines have no pull: show the inverse of the last level
    always @(host_oe, host_o, drv, dout)
        if (host_oe) line = host_o;
        else if (drv) line = dout;
        else line = ~line;
endmodule // asbp_sram_model

// *** asbp_host_tb_top.sv ***
// Self-checking testbench for the async SRAM host controller
module asbp_host_tb_top
    import asbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic srst;
    logic req_valid;
    asbp_req_t req;
    logic req_ready;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic retain_req;
    logic retain_ok;
    asbp_pins_t pins;
    logic [DATA_W-1:0] line;
    logic [DATA_W-1:0] host_o;
    logic host_oe;
    int viol;
    int err_total = 0;
    int comparisons = 0;
    logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]];

    always #50 core_clk = ~core_clk;

    asbp_host i_asbp_host (.core_clk(core_clk), .srst(srst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .retain_req(retain_req),
        .retain_ok(retain_ok), .pins(pins), .byte_data_lines_i(line),
        .byte_data_lines_o(host_o), .byte_data_lines_oe(host_oe));
    asbp_sram_model i_asbp_sram_model (.pins(pins), .host_o(host_o),
        .host_oe(host_oe), .retain_ok(retain_ok), .line(line), .viol(viol));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [DATA_W-1:0] exp_byte(logic [ADDR_W-1:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : (a[7:0] ^ 8'h5A);
    endfunction

    // Hold one request from a falling edge through the taking edge
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check(n < 20, 1);
        req_valid = 1'b1;
        req = '{write: wr, addr: a, wdata: d};
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        issue(1'b1, a, d);
        exp_mem[a] = d;
        check({host_oe, host_o, pins}, {1'b1, d, 4'b0110, a});
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        int n;
        issue(1'b0, a, '0);
        check(pins, {4'b0101, a});
        n = 0;
        while (rd_valid !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        check({rd_valid, rd_data}, {1'b1, exp_byte(a)});
    endtask

    initial begin
        int unsigned s;
        logic [ADDR_W-1:0] a;
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        retain_req = 1'b0;
        s = $urandom(32'h89AC2397);
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        check({host_oe, retain_ok, pins}, {2'b00, PINS_IDLE});
        // Extreme words, overwrite, then an unwritten word
        wr(19'h00000, 8'h00);
        wr(19'h7FFFF, 8'hFF);
        rd(19'h7FFFF);
        rd(19'h00000);
        wr(19'h00000, 8'hA5);
        rd(19'h00000);
        rd(19'h2AAAA);
        // Narrow pool half the time, so reads often hit earlier writes
        for (int i = 0; i < 60; i++) begin
            a = 19'($urandom) & ($urandom_range(1) ? 19'h7FFFF : 19'h0001F);
            if ($urandom_range(1))
                wr(a, 8'($urandom));
            else
                rd(a);
        end
        // A waiting request must not select a parked memory
        retain_req = 1'b1;
        req_valid = 1'b1;
        req = '{write: 1'b0, addr: 19'h00000, wdata: 8'h00};
        repeat (8) begin
            @(negedge core_clk);
            check({rd_valid, pins.select_active_low,
                   pins.select_active_high}, 3'b010);
        end
        check(retain_ok, 1'b1);
        retain_req = 1'b0;
        req_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        check(retain_ok, 1'b0);
        rd(19'h00000);
        check(viol, 0);
        stop_test();
    end

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        #(3000 * 100);
        $display("ERROR at %0t got %h exp %h", $time, 0, 1);
        err_total++;
        stop_test();
    end
endmodule // asbp_host_tb_top
